// ==== hdl/cpu_exec_pkg.sv ====
package cpu_exec_pkg;

	localparam int PC_W = 22;

	// register byte offsets
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_OPND   = 8'h04;
	localparam logic [7:0] ADDR_KVAL   = 8'h08;
	localparam logic [7:0] ADDR_PC     = 8'h0c;
	localparam logic [7:0] ADDR_ZPTR   = 8'h10;
	localparam logic [7:0] ADDR_STACK  = 8'h14;
	localparam logic [7:0] ADDR_SREG   = 8'h18;
	localparam logic [7:0] ADDR_RESULT = 8'h1c;
	localparam logic [7:0] ADDR_CIPHER = 8'h20;
	localparam logic [7:0] ADDR_STATUS = 8'h24;

	// field positions
	localparam int CTRL_WIDE_BIT  = 16;
	localparam int CTRL_TWO_BIT   = 17;
	localparam int CTRL_START_BIT = 31;
	localparam int STAT_LAT_LSB   = 4;
	localparam int SR_C           = 0;
	localparam int SR_Z           = 1;
	localparam int SR_N           = 2;
	localparam int SR_V           = 3;
	localparam int SR_S           = 4;
	localparam int SR_H           = 5;
	localparam int SR_I           = 7;

	// execution lengths in clk_sys cycles
	localparam logic [2:0] LAT_1 = 3'h1;
	localparam logic [2:0] LAT_2 = 3'h2;
	localparam logic [2:0] LAT_3 = 3'h3;
	localparam logic [2:0] LAT_4 = 3'h4;
	localparam logic [2:0] LAT_5 = 3'h5;

	typedef enum logic [4:0] {
		OP_MINUS_ONE, OP_ZERO_SIGN_TEST, OP_REGISTER_WIPE, OP_REGISTER_FILL_ONES,
		OP_PRODUCT_UNSIGNED, OP_PRODUCT_SIGNED, OP_PRODUCT_MIXED,
		OP_FRAC_PRODUCT_UNSIGNED, OP_FRAC_PRODUCT_SIGNED, OP_FRAC_PRODUCT_MIXED,
		OP_CIPHER_ROUND, OP_RELATIVE_GOTO, OP_ABSOLUTE_GOTO, OP_POINTER_GOTO,
		OP_FAR_POINTER_GOTO, OP_RELATIVE_INVOKE, OP_ABSOLUTE_INVOKE, OP_POINTER_INVOKE,
		OP_FAR_POINTER_INVOKE, OP_ROUTINE_EXIT, OP_IRQ_EXIT, OP_EQUAL_SKIP,
		OP_COMPARE_PLAIN, OP_COMPARE_CARRY, OP_COMPARE_IMMEDIATE,
		OP_REG_BIT_CLEAR_SKIP, OP_REG_BIT_SET_SKIP, OP_IO_BIT_CLEAR_SKIP,
		OP_IO_BIT_SET_SKIP
	} op_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} wb_rsp_t;

	typedef struct packed {
		logic            ack;
		logic [31:0]     datO;
		op_t             op;
		logic [2:0]      bitSel;
		logic            wide;
		logic            twoWord;
		logic [7:0]      rd;
		logic [7:0]      rr;
		logic [7:0]      ioVal;
		logic [PC_W-1:0] k;
		logic [PC_W-1:0] pc;
		logic [15:0]     z;
		logic [5:0]      pc_upper_extension;
		logic [PC_W-1:0] stack;
		logic [7:0]      sreg;
		logic [15:0]     result;
		logic [31:0]     cipher;
		logic            run;
		logic            busy;
		logic [2:0]      cnt;
		logic [2:0]      lastLat;
	} state_t;

	localparam state_t STATE_RESET = '0;

endpackage

// ==== hdl/cpu_arith_branch_exec.sv ====
// How it works
// (RL1) decrement, test, wipe set flags; fill keeps
// (RL2) products land in R1:R0, Z C, two cycles
// (RL3) fractional products shifted left one bit
// (RL4) cipher round: half-carry clear encrypts, set decrypts
// (RL5) relative, absolute, pointer goto targets and timing
// (RL6) far pointer goto takes upper bits from extension
// (RL7) relative and pointer invoke, two or three cycles
// (RL8) far pointer invoke uses extension, three cycles
// (RL9) absolute invoke, exits restore from stack
// (RL10) equal skip passes next instruction, no flags
// (RL11) compares subtract, set six flags, one cycle
// (RL12) register bit skips on clear or set
// (RL13) io bit skips leave flags alone
// (RL14) wide counter selects higher cycle count
`timescale 1ns/1ps
module cpu_arith_branch_exec (
	// system
	input  wire logic                   clk_sys,
	input  wire logic                   rst,
	// register bus
	input  wire cpu_exec_pkg::wb_req_t  wbReq,
	output cpu_exec_pkg::wb_rsp_t       wbRsp,
	// status
	output logic                        execBusy
);

	cpu_exec_pkg::state_t state_reg;
	cpu_exec_pkg::state_t state_next;

	function automatic logic [31:0] mergeSel(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
				m[8*i +: 8] = nw[8*i +: 8];
		end
		return m;
	endfunction

	function automatic logic [7:0] logicFlags(input logic [7:0] sr, input logic [7:0] r,
		input logic v);
		logic [7:0] s;
		s = sr;
		s[cpu_exec_pkg::SR_Z] = (r == 8'h00);
		s[cpu_exec_pkg::SR_N] = r[7];
		s[cpu_exec_pkg::SR_V] = v;
		s[cpu_exec_pkg::SR_S] = r[7] ^ v;
		return s;
	endfunction

	// subtraction flags; chained compare only keeps Z when result is zero
	function automatic logic [7:0] subFlags(input logic [7:0] sr, input logic [7:0] a,
		input logic [7:0] b, input logic cin, input logic chain);
		logic [7:0] s;
		logic [7:0] r;
		s = sr;
		r = a - b - {7'h00, cin};
		s[cpu_exec_pkg::SR_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
		s[cpu_exec_pkg::SR_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
		s[cpu_exec_pkg::SR_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
		s[cpu_exec_pkg::SR_N] = r[7];
		s[cpu_exec_pkg::SR_S] = r[7] ^ s[cpu_exec_pkg::SR_V];
		s[cpu_exec_pkg::SR_Z] = (r == 8'h00) & (~chain | sr[cpu_exec_pkg::SR_Z]);
		return s;
	endfunction

	// low 16 bits of a sign-extended product are exact for every mix
	function automatic logic [15:0] product(input logic [7:0] a, input logic [7:0] b,
		input logic sa, input logic sb);
		logic [15:0] ea;
		logic [15:0] eb;
		ea = {{8{sa & a[7]}}, a};
		eb = {{8{sb & b[7]}}, b};
		return ea * eb;
	endfunction

	// two-half keyed round; decrypt undoes encrypt with the same key
	function automatic logic [31:0] cipherRound(input logic [31:0] blk, input logic [7:0] key,
		input logic dec);
		logic [15:0] f;
		if (!dec)
		begin
			f = {blk[7:0] ^ key, blk[15:8] + key};
			return {blk[15:0], blk[31:16] ^ f};
		end
		f = {blk[23:16] ^ key, blk[31:24] + key};
		return {blk[15:0] ^ f, blk[31:16]};
	endfunction

	function automatic logic [2:0] latency(input cpu_exec_pkg::op_t op, input logic wide,
		input logic skip, input logic two);
		case (op)
			cpu_exec_pkg::OP_PRODUCT_UNSIGNED, cpu_exec_pkg::OP_PRODUCT_SIGNED,
			cpu_exec_pkg::OP_PRODUCT_MIXED, cpu_exec_pkg::OP_FRAC_PRODUCT_UNSIGNED,
			cpu_exec_pkg::OP_FRAC_PRODUCT_SIGNED, cpu_exec_pkg::OP_FRAC_PRODUCT_MIXED,
			cpu_exec_pkg::OP_RELATIVE_GOTO, cpu_exec_pkg::OP_POINTER_GOTO,
			cpu_exec_pkg::OP_FAR_POINTER_GOTO:
				return cpu_exec_pkg::LAT_2; // RL2 RL3 RL5 RL6
			cpu_exec_pkg::OP_ABSOLUTE_GOTO, cpu_exec_pkg::OP_FAR_POINTER_INVOKE:
				return cpu_exec_pkg::LAT_3; // RL5 RL8
			cpu_exec_pkg::OP_CIPHER_ROUND:
				return wide ? cpu_exec_pkg::LAT_2 : cpu_exec_pkg::LAT_1; // RL4 RL14
			cpu_exec_pkg::OP_RELATIVE_INVOKE, cpu_exec_pkg::OP_POINTER_INVOKE:
				return wide ? cpu_exec_pkg::LAT_3 : cpu_exec_pkg::LAT_2; // RL7 RL14
			cpu_exec_pkg::OP_ABSOLUTE_INVOKE:
				return wide ? cpu_exec_pkg::LAT_4 : cpu_exec_pkg::LAT_3; // RL9 RL14
			cpu_exec_pkg::OP_ROUTINE_EXIT, cpu_exec_pkg::OP_IRQ_EXIT:
				return wide ? cpu_exec_pkg::LAT_5 : cpu_exec_pkg::LAT_4; // RL9 RL14
			cpu_exec_pkg::OP_EQUAL_SKIP, cpu_exec_pkg::OP_REG_BIT_CLEAR_SKIP,
			cpu_exec_pkg::OP_REG_BIT_SET_SKIP, cpu_exec_pkg::OP_IO_BIT_CLEAR_SKIP,
			cpu_exec_pkg::OP_IO_BIT_SET_SKIP:
			begin
				if (!skip)
					return cpu_exec_pkg::LAT_1;
				return two ? cpu_exec_pkg::LAT_3 : cpu_exec_pkg::LAT_2; // RL10
			end
			default:
				return cpu_exec_pkg::LAT_1; // RL1 RL11
		endcase
	endfunction

	logic                          hit;
	logic                          locked;
	logic [31:0]                   rdat;
	logic [31:0]                   wdat;
	logic [cpu_exec_pkg::PC_W-1:0] pcInc;
	logic [cpu_exec_pkg::PC_W-1:0] pcNew;
	logic [7:0]                    srNew;
	logic [7:0]                    r8;
	logic [15:0]                   prod;
	logic                          skip;
	logic [2:0]                    lat;

	always_comb
	begin
		state_next = state_reg;
		state_next.ack = 1'b0;
		state_next.run = 1'b0;
		hit = wbReq.cyc & wbReq.stb & ~state_reg.ack;
		// operands and state stay frozen while an instruction is in flight
		locked = state_reg.run | state_reg.busy;
		rdat = '0;
		wdat = '0;
		pcInc = state_reg.pc + 22'h000001;
		pcNew = pcInc;
		srNew = state_reg.sreg;
		r8 = '0;
		prod = '0;
		skip = 1'b0;
		lat = cpu_exec_pkg::LAT_1;
		case (wbReq.adr)
			cpu_exec_pkg::ADDR_CTRL:
			begin
				rdat[4:0] = state_reg.op;
				rdat[10:8] = state_reg.bitSel;
				rdat[cpu_exec_pkg::CTRL_WIDE_BIT] = state_reg.wide;
				rdat[cpu_exec_pkg::CTRL_TWO_BIT] = state_reg.twoWord;
			end
			cpu_exec_pkg::ADDR_OPND:   rdat[23:0] = {state_reg.ioVal, state_reg.rr, state_reg.rd};
			cpu_exec_pkg::ADDR_KVAL:   rdat[21:0] = state_reg.k;
			cpu_exec_pkg::ADDR_PC:     rdat[21:0] = state_reg.pc;
			cpu_exec_pkg::ADDR_ZPTR:   rdat[21:0] = {state_reg.pc_upper_extension, state_reg.z};
			cpu_exec_pkg::ADDR_STACK:  rdat[21:0] = state_reg.stack;
			cpu_exec_pkg::ADDR_SREG:   rdat[7:0] = state_reg.sreg;
			cpu_exec_pkg::ADDR_RESULT: rdat[15:0] = state_reg.result;
			cpu_exec_pkg::ADDR_CIPHER: rdat = state_reg.cipher;
			cpu_exec_pkg::ADDR_STATUS:
			begin
				rdat[0] = locked;
				rdat[cpu_exec_pkg::STAT_LAT_LSB +: 3] = state_reg.lastLat;
			end
			default:   rdat = '0;
		endcase
		wdat = mergeSel(rdat, wbReq.dat, wbReq.sel);
		if (hit)
		begin
			state_next.ack = 1'b1;
			state_next.datO = rdat;
		end
		if (hit && wbReq.we && !locked)
		begin
			case (wbReq.adr)
				cpu_exec_pkg::ADDR_CTRL:
				begin
					state_next.op = cpu_exec_pkg::op_t'(wdat[4:0]);
					state_next.bitSel = wdat[10:8];
					state_next.wide = wdat[cpu_exec_pkg::CTRL_WIDE_BIT];
					state_next.twoWord = wdat[cpu_exec_pkg::CTRL_TWO_BIT];
					state_next.run = wbReq.sel[3] & wbReq.dat[cpu_exec_pkg::CTRL_START_BIT];
				end
				cpu_exec_pkg::ADDR_OPND:
					{state_next.ioVal, state_next.rr, state_next.rd} = wdat[23:0];
				cpu_exec_pkg::ADDR_KVAL:   state_next.k = wdat[21:0];
				cpu_exec_pkg::ADDR_PC:     state_next.pc = wdat[21:0];
				cpu_exec_pkg::ADDR_ZPTR:   {state_next.pc_upper_extension, state_next.z} = wdat[21:0];
				cpu_exec_pkg::ADDR_STACK:  state_next.stack = wdat[21:0];
				cpu_exec_pkg::ADDR_SREG:   state_next.sreg = wdat[7:0];
				cpu_exec_pkg::ADDR_CIPHER: state_next.cipher = wdat;
				default:   ;
			endcase
		end
		if (state_reg.run)
		begin
			case (state_reg.op)
				cpu_exec_pkg::OP_MINUS_ONE:
				begin
					r8 = state_reg.rd - 8'h01;
					srNew = logicFlags(state_reg.sreg, r8, state_reg.rd == 8'h80); // RL1
				end
				cpu_exec_pkg::OP_ZERO_SIGN_TEST:
				begin
					r8 = state_reg.rd & state_reg.rd;
					srNew = logicFlags(state_reg.sreg, r8, 1'b0); // RL1
				end
				cpu_exec_pkg::OP_REGISTER_WIPE:
				begin
					r8 = state_reg.rd ^ state_reg.rd;
					srNew = logicFlags(state_reg.sreg, r8, 1'b0); // RL1
				end
				cpu_exec_pkg::OP_REGISTER_FILL_ONES: r8 = 8'hff; // RL1
				cpu_exec_pkg::OP_PRODUCT_UNSIGNED:
					prod = product(state_reg.rd, state_reg.rr, 1'b0, 1'b0); // RL2
				cpu_exec_pkg::OP_PRODUCT_SIGNED, cpu_exec_pkg::OP_FRAC_PRODUCT_SIGNED:
					prod = product(state_reg.rd, state_reg.rr, 1'b1, 1'b1); // RL2
				cpu_exec_pkg::OP_PRODUCT_MIXED, cpu_exec_pkg::OP_FRAC_PRODUCT_MIXED:
					prod = product(state_reg.rd, state_reg.rr, 1'b1, 1'b0); // RL2
				cpu_exec_pkg::OP_FRAC_PRODUCT_UNSIGNED:
					prod = product(state_reg.rd, state_reg.rr, 1'b0, 1'b0); // RL3
				cpu_exec_pkg::OP_CIPHER_ROUND:
					state_next.cipher = cipherRound(state_reg.cipher, state_reg.k[7:0],
						state_reg.sreg[cpu_exec_pkg::SR_H]); // RL4
				cpu_exec_pkg::OP_RELATIVE_GOTO, cpu_exec_pkg::OP_RELATIVE_INVOKE:
					pcNew = pcInc + {{10{state_reg.k[11]}}, state_reg.k[11:0]}; // RL5 RL7
				cpu_exec_pkg::OP_ABSOLUTE_GOTO, cpu_exec_pkg::OP_ABSOLUTE_INVOKE:
					pcNew = state_reg.k; // RL5 RL9
				cpu_exec_pkg::OP_POINTER_GOTO, cpu_exec_pkg::OP_POINTER_INVOKE:
					pcNew = {6'h00, state_reg.z}; // RL5 RL7
				cpu_exec_pkg::OP_FAR_POINTER_GOTO, cpu_exec_pkg::OP_FAR_POINTER_INVOKE:
					pcNew = {state_reg.pc_upper_extension, state_reg.z}; // RL6 RL8
				cpu_exec_pkg::OP_ROUTINE_EXIT:  pcNew = state_reg.stack; // RL9
				cpu_exec_pkg::OP_IRQ_EXIT:
				begin
					pcNew = state_reg.stack;
					srNew[cpu_exec_pkg::SR_I] = 1'b1; // RL9
				end
				cpu_exec_pkg::OP_EQUAL_SKIP:    skip = state_reg.rd == state_reg.rr; // RL10
				cpu_exec_pkg::OP_COMPARE_PLAIN:
					srNew = subFlags(state_reg.sreg, state_reg.rd, state_reg.rr, 1'b0, 1'b0); // RL11
				cpu_exec_pkg::OP_COMPARE_CARRY:
					srNew = subFlags(state_reg.sreg, state_reg.rd, state_reg.rr,
						state_reg.sreg[cpu_exec_pkg::SR_C], 1'b1); // RL11
				cpu_exec_pkg::OP_COMPARE_IMMEDIATE:
					srNew = subFlags(state_reg.sreg, state_reg.rd, state_reg.k[7:0], 1'b0, 1'b0); // RL11
				cpu_exec_pkg::OP_REG_BIT_CLEAR_SKIP: skip = ~state_reg.rr[state_reg.bitSel]; // RL12
				cpu_exec_pkg::OP_REG_BIT_SET_SKIP:   skip = state_reg.rr[state_reg.bitSel]; // RL12
				cpu_exec_pkg::OP_IO_BIT_CLEAR_SKIP:  skip = ~state_reg.ioVal[state_reg.bitSel]; // RL13
				cpu_exec_pkg::OP_IO_BIT_SET_SKIP:    skip = state_reg.ioVal[state_reg.bitSel]; // RL13
				default: ;
			endcase
			case (state_reg.op)
				cpu_exec_pkg::OP_MINUS_ONE, cpu_exec_pkg::OP_ZERO_SIGN_TEST,
				cpu_exec_pkg::OP_REGISTER_WIPE, cpu_exec_pkg::OP_REGISTER_FILL_ONES:
					state_next.result = {8'h00, r8};
				cpu_exec_pkg::OP_PRODUCT_UNSIGNED, cpu_exec_pkg::OP_PRODUCT_SIGNED,
				cpu_exec_pkg::OP_PRODUCT_MIXED:
				begin
					state_next.result = prod;
					srNew[cpu_exec_pkg::SR_C] = prod[15];
					srNew[cpu_exec_pkg::SR_Z] = (prod == 16'h0000); // RL2
				end
				cpu_exec_pkg::OP_FRAC_PRODUCT_UNSIGNED, cpu_exec_pkg::OP_FRAC_PRODUCT_SIGNED,
				cpu_exec_pkg::OP_FRAC_PRODUCT_MIXED:
				begin
					// carry takes the bit pushed out by the shift
					state_next.result = {prod[14:0], 1'b0};
					srNew[cpu_exec_pkg::SR_C] = prod[15];
					srNew[cpu_exec_pkg::SR_Z] = (prod[14:0] == 15'h0000); // RL3
				end
				cpu_exec_pkg::OP_RELATIVE_INVOKE, cpu_exec_pkg::OP_POINTER_INVOKE,
				cpu_exec_pkg::OP_FAR_POINTER_INVOKE:
					state_next.stack = pcInc; // RL7 RL8
				cpu_exec_pkg::OP_ABSOLUTE_INVOKE:
					state_next.stack = pcInc + 22'h000001; // RL9
				default: ;
			endcase
			// skipped instruction may itself be two words long
			if (skip)
				pcNew = pcInc + 22'h000001 + {21'h000000, state_reg.twoWord}; // RL10 RL12 RL13
			lat = latency(state_reg.op, state_reg.wide, skip, state_reg.twoWord); // RL14
			state_next.pc = pcNew;
			state_next.sreg = srNew;
			state_next.busy = 1'b1;
			state_next.cnt = lat - 3'h1;
			state_next.lastLat = lat;
		end
		else if (state_reg.busy)
		begin
			if (state_reg.cnt == 3'h0)
				state_next.busy = 1'b0;
			else
				state_next.cnt = state_reg.cnt - 3'h1;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			state_reg <= cpu_exec_pkg::STATE_RESET;
		else
			state_reg <= state_next;
	end

	assign wbRsp.ack = state_reg.ack;
	assign wbRsp.dat = state_reg.datO;
	assign execBusy = state_reg.busy;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_dec_value: assert property (state_reg.run && state_reg.op == cpu_exec_pkg::OP_MINUS_ONE
		|=> state_reg.result[7:0] == $past(state_reg.rd) - 8'h01 ##0 state_reg.busy
		##1 !state_reg.busy) else $error("decrement wrong"); // RL1
	a_fill_flags: assert property (state_reg.run
		&& state_reg.op == cpu_exec_pkg::OP_REGISTER_FILL_ONES
		|=> state_reg.result[7:0] == 8'hff && state_reg.sreg == $past(state_reg.sreg))
		else $error("fill changed flags"); // RL1
	a_mul_pair: assert property (state_reg.run && state_reg.op == cpu_exec_pkg::OP_PRODUCT_UNSIGNED
		|=> (state_reg.result == {8'h00, $past(state_reg.rd)} * {8'h00, $past(state_reg.rr)})
		##0 state_reg.busy[*2] ##1 !state_reg.busy) else $error("product wrong"); // RL2
	a_frac_shift: assert property (state_reg.run
		&& state_reg.op == cpu_exec_pkg::OP_FRAC_PRODUCT_UNSIGNED
		|=> state_reg.result == ({8'h00, $past(state_reg.rd)} * {8'h00, $past(state_reg.rr)}) << 1)
		else $error("fractional product wrong"); // RL3
	a_cipher_dir: assert property (state_reg.run && state_reg.op == cpu_exec_pkg::OP_CIPHER_ROUND
		|=> cipherRound(state_reg.cipher, state_reg.k[7:0], ~state_reg.sreg[cpu_exec_pkg::SR_H])
		== $past(state_reg.cipher)) else $error("cipher direction wrong"); // RL4
	a_ptr_goto: assert property (state_reg.run && state_reg.op == cpu_exec_pkg::OP_POINTER_GOTO
		|=> state_reg.pc == {6'h00, $past(state_reg.z)} ##0 state_reg.busy[*2] ##1 !state_reg.busy)
		else $error("pointer goto wrong"); // RL5
	a_far_goto: assert property (state_reg.run && state_reg.op == cpu_exec_pkg::OP_FAR_POINTER_GOTO
		|=> state_reg.pc == {$past(state_reg.pc_upper_extension), $past(state_reg.z)})
		else $error("far goto wrong"); // RL6
	a_ptr_invoke: assert property (state_reg.run && !state_reg.wide
		&& state_reg.op == cpu_exec_pkg::OP_POINTER_INVOKE
		|=> state_reg.stack == $past(state_reg.pc) + 22'h000001 ##0 state_reg.busy[*2]
		##1 !state_reg.busy) else $error("pointer invoke wrong"); // RL7
	a_far_invoke: assert property (state_reg.run
		&& state_reg.op == cpu_exec_pkg::OP_FAR_POINTER_INVOKE
		|=> state_reg.busy[*3] ##1 !state_reg.busy) else $error("far invoke length"); // RL8
	a_exit_wide: assert property (state_reg.run && state_reg.wide
		&& state_reg.op == cpu_exec_pkg::OP_IRQ_EXIT
		|=> state_reg.pc == $past(state_reg.stack) && state_reg.sreg[cpu_exec_pkg::SR_I]
		##0 state_reg.busy[*5] ##1 !state_reg.busy) else $error("irq exit wrong"); // RL9
	a_eq_skip: assert property (state_reg.run && state_reg.op == cpu_exec_pkg::OP_EQUAL_SKIP
		&& state_reg.rd == state_reg.rr |=> state_reg.pc == $past(state_reg.pc) + 22'h000002
		+ {21'h000000, $past(state_reg.twoWord)} && state_reg.sreg == $past(state_reg.sreg))
		else $error("equal skip wrong"); // RL10
	a_cmp_flags: assert property (state_reg.run && state_reg.op == cpu_exec_pkg::OP_COMPARE_PLAIN
		|=> state_reg.sreg[cpu_exec_pkg::SR_Z] == ($past(state_reg.rd) == $past(state_reg.rr))
		&& state_reg.sreg[cpu_exec_pkg::SR_C] == ($past(state_reg.rd) < $past(state_reg.rr))
		##1 !state_reg.busy) else $error("compare flags wrong"); // RL11
	a_bit_noskip: assert property (state_reg.run && state_reg.op == cpu_exec_pkg::OP_REG_BIT_SET_SKIP
		&& !state_reg.rr[state_reg.bitSel] |=> state_reg.pc == $past(state_reg.pc) + 22'h000001)
		else $error("bit skip wrong"); // RL12
	a_io_flags: assert property (state_reg.run && state_reg.op inside
		{cpu_exec_pkg::OP_IO_BIT_CLEAR_SKIP, cpu_exec_pkg::OP_IO_BIT_SET_SKIP}
		|=> state_reg.sreg == $past(state_reg.sreg)) else $error("io skip touched flags"); // RL13
	a_exit_narrow: assert property (state_reg.run && !state_reg.wide
		&& state_reg.op == cpu_exec_pkg::OP_ROUTINE_EXIT
		|=> state_reg.busy[*4] ##1 !state_reg.busy) else $error("narrow exit length"); // RL14

	c_two_word_skip: cover property (state_reg.run && state_reg.twoWord
		&& state_reg.op == cpu_exec_pkg::OP_EQUAL_SKIP && state_reg.rd == state_reg.rr);
	c_decrypt: cover property (state_reg.run && state_reg.sreg[cpu_exec_pkg::SR_H]
		&& state_reg.op == cpu_exec_pkg::OP_CIPHER_ROUND);
	c_signed_mul: cover property (state_reg.run && state_reg.rd[7]
		&& state_reg.op == cpu_exec_pkg::OP_FRAC_PRODUCT_SIGNED);
	c_wide_invoke: cover property (state_reg.run && state_reg.wide
		&& state_reg.op == cpu_exec_pkg::OP_ABSOLUTE_INVOKE);

endmodule

// ==== verification/wb_master_model.sv ====
`timescale 1ns/1ps
module wb_master_model (
	// system
	input  wire logic                  clk_sys,
	// register bus
	output cpu_exec_pkg::wb_req_t      wbReq,
	input  wire cpu_exec_pkg::wb_rsp_t wbRsp
);
	initial wbReq = '0;

	// request held until ack is seen at an edge; the bench watchdog ends a wait on a dead slave
	task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
		output logic [31:0] rdat);
		@(posedge clk_sys);
		wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
		do
			@(posedge clk_sys);
		while (wbRsp.ack !== 1'b1);
		rdat = wbRsp.dat;
		wbReq <= '0;
	endtask
endmodule

// ==== verification/cpu_arith_branch_exec_tb.sv ====
`timescale 1ns/1ps
module cpu_arith_branch_exec_tb;
	logic                  clk_sys;
	logic                  rst;
	cpu_exec_pkg::wb_req_t wbReq;
	cpu_exec_pkg::wb_rsp_t wbRsp;
	logic                  execBusy;
	int                    mismatches;
	int                    compares;
	logic [7:0]            rd, rr, io, sreg;
	logic [21:0]           k, pc, stack;
	logic [15:0]           z;
	logic [5:0]            pc_upper_extension;
	logic [2:0]            bsel;
	logic                  wide, two;
	logic [31:0]           rdat, blk;

	cpu_arith_branch_exec u_dut (.clk_sys(clk_sys), .rst(rst), .wbReq(wbReq), .wbRsp(wbRsp),
		.execBusy(execBusy));
	wb_master_model u_master (.clk_sys(clk_sys), .wbReq(wbReq), .wbRsp(wbRsp));

	initial clk_sys = 1'b0;
	always #2.5 clk_sys = ~clk_sys;

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_master.xfer(1'b1, a, d, rdat);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string w);
		u_master.xfer(1'b0, a, 32'h0, rdat);
		check(rdat, e, w);
	endtask

	function automatic logic taken(input int op);
		case (op)
			21: return rd == rr;
			25: return !rr[bsel];
			26: return rr[bsel];
			27: return !io[bsel];
			28: return io[bsel];
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic [2:0] expLat(input int op, input logic tk);
		case (op)
			10: return wide ? 3'h2 : 3'h1;
			15, 17: return wide ? 3'h3 : 3'h2;
			16: return wide ? 3'h4 : 3'h3;
			19, 20: return wide ? 3'h5 : 3'h4;
			4, 5, 6, 7, 8, 9, 11, 13, 14: return 3'h2;
			12, 18: return 3'h3;
			21, 25, 26, 27, 28: return tk ? (two ? 3'h3 : 3'h2) : 3'h1;
			default: return 3'h1;
		endcase
	endfunction

	function automatic logic [21:0] expPc(input int op, input logic tk);
		case (op)
			11, 15: return pc + {{10{k[11]}}, k[11:0]} + 22'h1;
			12, 16: return k;
			13, 17: return {6'h0, z};
			14, 18: return {pc_upper_extension, z};
			19, 20: return stack;
			default: return pc + (tk ? (two ? 22'h3 : 22'h2) : 22'h1);
		endcase
	endfunction

	// flags in the upper byte, result word below
	function automatic logic [23:0] expRes(input int op);
		logic [15:0] p;
		logic [7:0]  s, r, b;
		logic        cin, v;
		s = sreg;
		p = 16'h0;
		case (op)
			0, 1, 2:
			begin
				r = (op == 0) ? rd - 8'h1 : (op == 1) ? rd : 8'h0;
				v = (op == 0) && (rd == 8'h80);
				s[4:1] = {r[7] ^ v, v, r[7], r == 8'h0};
				p = {8'h0, r};
			end
			3: p = 16'h00ff;
			4, 7: p = rd * rr;
			5, 8: p = $signed({{8{rd[7]}}, rd}) * $signed({{8{rr[7]}}, rr});
			6, 9: p = $signed({{8{rd[7]}}, rd}) * $signed({8'h0, rr});
			22, 23, 24:
			begin
				b = (op == 24) ? k[7:0] : rr;
				cin = (op == 23) && sreg[0];
				r = rd - b - cin;
				s[0] = (~rd[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~rd[7]);
				s[5] = (~rd[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~rd[3]);
				v = (rd[7] & ~b[7] & ~r[7]) | (~rd[7] & b[7] & r[7]);
				s[4:1] = {r[7] ^ v, v, r[7], (r == 8'h0) && (op != 23 || sreg[1])};
			end
			20: s[7] = 1'b1;
			default: s = sreg;
		endcase
		if (op >= 4 && op <= 9)
		begin
			s[0] = p[15];
			if (op >= 7)
				p = p << 1;
			s[1] = p == 16'h0;
		end
		return {s, p};
	endfunction

	task automatic exec(input int op);
		logic [23:0] e;
		logic        tk;
		int          n;
		logic [21:0] ret;
		tk = taken(op);
		e = expRes(op);
		n = 0;
		wr(8'h04, {8'h0, io, rr, rd});
		wr(8'h08, {10'h0, k});
		wr(8'h0c, {10'h0, pc});
		wr(8'h10, {10'h0, pc_upper_extension, z});
		wr(8'h14, {10'h0, stack});
		wr(8'h18, {24'h0, sreg});
		wr(8'h00, {1'b1, 13'h0, two, wide, 5'h0, bsel, 3'h0, op[4:0]});
		for (int i = 0; i < 8; i++)
		begin
			#1;
			if (execBusy === 1'b1)
				n++;
			@(posedge clk_sys);
		end
		check(n, {29'h0, expLat(op, tk)}, "busy length");
		rdchk(8'h24, {25'h0, expLat(op, tk), 4'h0}, "status");
		rdchk(8'h0c, {10'h0, expPc(op, tk)}, "pc");
		rdchk(8'h18, {24'h0, e[23:16]}, "flags");
		ret = (op == 16) ? pc + 22'h2 : stack;
		if (op inside {15, 17, 18})
			ret = pc + 22'h1;
		rdchk(8'h14, {10'h0, ret}, "stack");
		if (op >= 4 && op <= 9)
			rdchk(8'h1c, {16'h0, e[15:0]}, "product");
		if (op < 4)
		begin
			u_master.xfer(1'b0, 8'h1c, 32'h0, rdat);
			check(rdat[7:0], e[7:0], "low result");
		end
	endtask

	task automatic conclude();
		if (mismatches == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial
	begin
		#200000;
		mismatches++;
		conclude();
	end

	initial
	begin
		mismatches = 0;
		compares = 0;
		rst = 1'b1;
		rdat = $urandom(32'h59e54ab4);
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		rdchk(8'h0c, 32'h0, "pc after reset");
		rdchk(8'h18, 32'h0, "flags after reset");
		rdchk(8'h3c, 32'h0, "unmapped read");
		// every code once, both counter widths, negative offset
		{rd, rr, io, sreg, stack} = {8'h80, 8'h80, 8'h01, 8'h40, 22'h12345};
		{k, pc, z, pc_upper_extension, bsel} = {22'h3ffffe, 22'h000100, 16'hbeef, 6'h2a, 3'h7};
		for (int op = 0; op < 32; op++)
		begin
			{two, wide} = op[1:0];
			exec(op);
		end
		for (int i = 0; i < 120; i++)
		begin
			{rd, rr, io, sreg} = $urandom;
			{k, pc_upper_extension, bsel, wide} = $urandom;
			{pc, two} = 23'($urandom);
			stack = 22'($urandom);
			z = 16'($urandom);
			if (i % 4 == 0)
				rr = rd;
			exec($urandom % 32);
		end
		blk = $urandom;
		wr(8'h20, blk);
		sreg = 8'h00;
		exec(10);
		u_master.xfer(1'b0, 8'h20, 32'h0, rdat);
		check(32'(rdat !== blk), 32'h1, "cipher changes block");
		sreg = 8'h20;
		exec(10);
		rdchk(8'h20, blk, "cipher round trip");
		// a write landing while the wide exit is still busy must be dropped
		wr(8'h14, 32'h00000abc);
		wr(8'h00, 32'h80010013);
		wr(8'h0c, 32'h00000123);
		rdchk(8'h0c, 32'h00000abc, "write while busy");
		conclude();
	end
endmodule
